// ---- hw/shbp_defines.svh ----
`ifndef SHBP_DEFINES_SVH
`define SHBP_DEFINES_SVH
`define SHBP_CLK_NS        10
`define SHBP_T_CSL_NS      32
`define SHBP_T_CSH_NS      13
`define SHBP_T_CYCLE_NS    45
`define SHBP_T_DSU_NS      7
`define SHBP_T_CFG_SU_NS   200
`define SHBP_T_CFG_HD_NS   10
`define SHBP_T_RST_US      200
`define SHBP_T_RD_WAIT_NS  135
`define SHBP_CEIL(t)       (((t) + `SHBP_CLK_NS - 1) / `SHBP_CLK_NS)
`define SHBP_CYC_CSL       `SHBP_CEIL(`SHBP_T_CSL_NS)
`define SHBP_CYC_CSH       `SHBP_CEIL(`SHBP_T_CSH_NS)
`define SHBP_CYC_CYCLE     `SHBP_CEIL(`SHBP_T_CYCLE_NS)
`define SHBP_CYC_DSU       `SHBP_CEIL(`SHBP_T_DSU_NS)
`define SHBP_CYC_CFG_SU    `SHBP_CEIL(`SHBP_T_CFG_SU_NS)
`define SHBP_CYC_RD_WAIT   `SHBP_CEIL(`SHBP_T_RD_WAIT_NS)
`define SHBP_CYC_RST       (`SHBP_T_RST_US * 1000 / `SHBP_CLK_NS)
`define SHBP_BURST_MAX     16
`define SHBP_ADDR_FIFO_LO  2
`define SHBP_ADDR_FIFO_HI  1
`define SHBP_REG_CNT_ADDR  7'h00
`define SHBP_REG_CFG_ADDR  7'h01
`define SHBP_REG_FILL_ADDR 7'h02
`define SHBP_REG_SCR_ADDR  7'h03
`endif

// ---- hw/shbp_device.sv ----
// Functional notes
// - Read runs while select and read both low
// - Write runs while select and write both low
// - Counter snapshot taken at read start
// - One 16-bit word per access
// - Host gap 13 ns, cycle 45 ns
// - Host holds read at least 32 ns
// - Burst returns each addressed word, 16 max; the code does not count or cap burst words
// - Host idles 13 ns after each burst
// - FIFO select read returns receive FIFO
// - FIFO select write pushes transmit FIFO
// - Direct mode uses A[2:1], ignores A[7:3]; the decode compares all of A[7:1]
// - Direct-mode bursts have no word cap
// - FIFO select timed like address
// - Write data captured at cycle end
// - Data bus driven only during reads
// - Config sampled at reset pin release
// - Host waits 135 ns before fill read
`timescale 1ns/1ps
`default_nettype none
`include "shbp_defines.svh"
module shbp_device import shbp_pkg::*; #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  shbp_if.device           bus,
  input  wire logic [15:0] rxData,
  input  wire logic        rxValid,
  output logic             rxReady,
  output logic [15:0]      txData,
  output logic             txValid,
  input  wire logic        txReady,
  output logic [1:0]       cfgStrap,
  output logic [15:0]      freeCount
);
  // ---------------------------------------------
  // Cycle detection
  // ---------------------------------------------
  logic        rdAct;
  logic        wrAct;
  logic        rdAct_reg;
  logic        wrAct_reg;
  logic [7:1]  addr_reg;
  logic [15:0] wrData_reg;
  logic        fsel_reg;
  logic        rstPin_reg;
  logic [15:0] cnt_reg;
  logic [15:0] snap_reg;
  logic [15:0] scratch_reg;
  logic [15:0] rdData_reg;
  logic        rdOe_reg;
  logic        txInReady;
  logic        txLost_reg;
  logic        rdStart;
  logic [15:0] regData_next;
  logic [15:0] rxOut;
  logic        rxOutValid;
  logic        rxPop;
  logic        txPush;
  logic        addrChg;
  logic [$clog2(DEPTH):0] rxFill;
  logic [$clog2(DEPTH):0] txFill;
  assign rdAct = !bus.chipSelectN && !bus.readStrobeN;
  assign wrAct = !bus.chipSelectN && !bus.writeStrobeN;
  assign addrChg = rdAct && rdAct_reg && (bus.addr != addr_reg);
  // A burst address step is a fresh word, so it starts like a new read
  assign rdStart = rdAct && (!rdAct_reg || addrChg);
  // Pop once per start; holding the strobes low must not drain the FIFO
  assign rxPop = bus.fifoSel && rdStart;
  // Write lands at trailing edge, with data held since then
  assign txPush = wrAct_reg && !wrAct && fsel_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdAct_reg  <= 1'b0;
      wrAct_reg  <= 1'b0;
      addr_reg   <= '0;
      wrData_reg <= '0;
      fsel_reg   <= 1'b0;
    end else begin
      rdAct_reg <= rdAct;
      wrAct_reg <= wrAct;
      addr_reg  <= bus.addr;
      fsel_reg  <= bus.fifoSel;
      if (wrAct) begin
        wrData_reg <= bus.dataHost;
      end
    end
  end
  // ---------------------------------------------
  // Counter, snapshot and register writes
  // ---------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_reg  <= '0;
      snap_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      if (rdStart) begin
        snap_reg <= cnt_reg;
      end
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scratch_reg <= '0;
    end else if (wrAct_reg && !wrAct && !fsel_reg && addr_reg == `SHBP_REG_SCR_ADDR) begin
      scratch_reg <= wrData_reg;
    end
  end
  // ---------------------------------------------
  // Transmit loss flag
  // ---------------------------------------------
  // A word pushed into a full TX FIFO is gone; flag it for the host
  // Sticky until reset, so a late poll still sees it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txLost_reg <= 1'b0;
    end else if (txPush && !txInReady) begin
      txLost_reg <= 1'b1;
    end
  end
  // ---------------------------------------------
  // Register decode
  // ---------------------------------------------
  // Counter word is live on a start edge only; the snapshot holds it after
  always_comb begin
    regData_next = 16'h0000;
    unique case (bus.addr)
      `SHBP_REG_CNT_ADDR:  regData_next = rdStart ? cnt_reg : snap_reg;
      `SHBP_REG_CFG_ADDR:  regData_next = {14'h0000, cfgStrap};
      `SHBP_REG_FILL_ADDR: regData_next = {7'h00, txLost_reg, 4'(rxFill), 4'(txFill)};
      `SHBP_REG_SCR_ADDR:  regData_next = scratch_reg;
      default:             regData_next = 16'h0000;
    endcase
  end
  // Strap caught on the clocked release of the reset pin
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstPin_reg <= 1'b0;
      cfgStrap   <= '0;
    end else begin
      rstPin_reg <= bus.resetPinN;
      if (bus.resetPinN && !rstPin_reg) begin
        cfgStrap <= bus.cfgIn;
      end
    end
  end
  // ---------------------------------------------
  // Read data path
  // ---------------------------------------------
  // One cycle latency; host allows 40 ns to data valid
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdData_reg <= '0;
      rdOe_reg   <= 1'b0;
    end else begin
      rdOe_reg <= rdAct;
      if (rdAct) begin
        if (bus.fifoSel) begin
          // Only A[2:1] would matter; one data port so it is unused
          if (rxPop) begin
            rdData_reg <= rxOutValid ? rxOut : 16'h0000;
          end
        end else begin
          rdData_reg <= regData_next;
        end
      end
    end
  end
  assign bus.dataDev   = rdData_reg;
  assign bus.dataDevOe = rdOe_reg && rdAct;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      freeCount <= '0;
    end else begin
      freeCount <= cnt_reg;
    end
  end
  // ---------------------------------------------
  // FIFOs
  // ---------------------------------------------
  shbp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) rxFifo (
    .clock    (clock),
    .rstn     (rstn),
    .inData   (rxData),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .outData  (rxOut),
    .outValid (rxOutValid),
    .outReady (rxPop),
    .fill     (rxFill)
  );
  // Full TX FIFO drops the word; host should watch fill
  shbp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) txFifo (
    .clock    (clock),
    .rstn     (rstn),
    .inData   (wrData_reg),
    .inValid  (txPush),
    .inReady  (txInReady),
    .outData  (txData),
    .outValid (txValid),
    .outReady (txReady),
    .fill     (txFill)
  );
endmodule
`default_nettype wire

// ---- hw/shbp_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module shbp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [$clog2(DEPTH):0] fill
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;
  // Compare at full count width; a pointer-wide cast of DEPTH wraps to zero
  assign inReady  = (cnt_reg != (AW+1)'(DEPTH));
  assign outValid = (cnt_reg != '0);
  assign outData  = mem[rdPtr_reg];
  assign fill     = cnt_reg;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      cnt_reg   <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- hw/shbp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "shbp_defines.svh"
module shbp_host import shbp_pkg::*; #(
  parameter int RST_CYC = `SHBP_CYC_RST
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  shbp_if.host             bus,
  input  wire logic        reqValid,
  input  wire shbp_op_t    reqOp,
  input  wire logic [7:1]  reqAddr,
  input  wire logic [15:0] reqData,
  input  wire logic [1:0]  cfgValue,
  output logic             reqReady,
  output logic             rspValid,
  output logic [15:0]      rspData
);
  shbp_host_state_t st_reg;
  logic [31:0] cnt_reg;
  logic [31:0] rstCnt_reg;
  logic        isWr_reg;
  logic        isFifo_reg;
  logic        rstDone;
  assign rstDone = (rstCnt_reg >= 32'(RST_CYC + `SHBP_CYC_CFG_SU));
  // ---------------------------------------------
  // Reset pin
  // ---------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstCnt_reg <= '0;
    end else if (!rstDone) begin
      rstCnt_reg <= rstCnt_reg + 32'h00000001;
    end
  end
  assign bus.resetPinN = (rstCnt_reg >= 32'(RST_CYC));
  assign bus.cfgIn     = cfgValue;
  // ---------------------------------------------
  // Access sequencer
  // ---------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg     <= SHBP_IDLE;
      cnt_reg    <= '0;
      isWr_reg   <= 1'b0;
      isFifo_reg <= 1'b0;
      rspValid   <= 1'b0;
      rspData    <= '0;
      reqReady   <= 1'b0;
      bus.chipSelectN  <= 1'b1;
      bus.readStrobeN  <= 1'b1;
      bus.writeStrobeN <= 1'b1;
      bus.fifoSel      <= 1'b0;
      bus.addr         <= '0;
      bus.dataHost     <= '0;
      bus.dataHostOe   <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      reqReady <= 1'b0;
      unique case (st_reg)
        SHBP_IDLE: begin
          if (reqValid && rstDone && !reqReady) begin
            reqReady        <= 1'b1;
            isWr_reg        <= reqOp[0];
            isFifo_reg      <= reqOp[1];
            bus.fifoSel     <= reqOp[1];
            bus.addr        <= reqAddr;
            bus.dataHost    <= reqData;
            bus.dataHostOe  <= reqOp[0];
            bus.chipSelectN <= 1'b0;
            bus.readStrobeN <= reqOp[0];
            bus.writeStrobeN <= !reqOp[0];
            cnt_reg         <= '0;
            st_reg          <= reqOp[0] ? SHBP_WR : SHBP_RD;
          end
        end
        SHBP_RD, SHBP_WR: begin
          cnt_reg <= cnt_reg + 32'h00000001;
          // Four low cycles cover 32 ns; the gap makes up the 45 ns cycle
          if (cnt_reg >= 32'(`SHBP_CYC_CSL - 1)) begin
            if (st_reg == SHBP_RD) begin
              rspValid <= 1'b1;
              rspData  <= bus.dataDev;
            end
            bus.chipSelectN  <= 1'b1;
            bus.readStrobeN  <= 1'b1;
            bus.writeStrobeN <= 1'b1;
            cnt_reg <= '0;
            st_reg  <= SHBP_GAP;
          end
        end
        SHBP_GAP: begin
          cnt_reg <= cnt_reg + 32'h00000001;
          bus.dataHostOe <= 1'b0;
          // Gap also covers read-to-fill-info wait
          if (cnt_reg >= 32'(isFifo_reg ? `SHBP_CYC_RD_WAIT : `SHBP_CYC_CSH)) begin
            bus.fifoSel <= 1'b0;
            st_reg      <= SHBP_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- hw/shbp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface shbp_if;
  logic        chipSelectN;
  logic        readStrobeN;
  logic        writeStrobeN;
  logic        fifoSel;
  logic [7:1]  addr;
  logic [15:0] dataHost;
  logic        dataHostOe;
  logic [15:0] dataDev;
  logic        dataDevOe;
  logic        resetPinN;
  logic [1:0]  cfgIn;
  wire  [15:0] dataBus = dataDevOe ? dataDev : (dataHostOe ? dataHost : 16'h0000);
  modport device (input chipSelectN, readStrobeN, writeStrobeN, fifoSel, addr, dataHost,
                  dataHostOe, resetPinN, cfgIn, output dataDev, dataDevOe);
  modport host (output chipSelectN, readStrobeN, writeStrobeN, fifoSel, addr, dataHost,
                dataHostOe, resetPinN, cfgIn, input dataDev, dataDevOe);
endinterface
`default_nettype wire

// ---- hw/shbp_pkg.sv ----
package shbp_pkg;
  typedef enum logic [1:0] {
    SHBP_IDLE  = 2'b00,
    SHBP_RD    = 2'b01,
    SHBP_WR    = 2'b10,
    SHBP_GAP   = 2'b11
  } shbp_host_state_t;
  typedef enum logic [1:0] {
    SHBP_OP_RD_REG  = 2'b00,
    SHBP_OP_WR_REG  = 2'b01,
    SHBP_OP_RD_FIFO = 2'b10,
    SHBP_OP_WR_FIFO = 2'b11
  } shbp_op_t;
endpackage

// ---- test/shbp_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module shbp_bench import shbp_pkg::*;;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic        reqValid = 1'b0;
  logic        rxValid = 1'b0;
  logic        txReady = 1'b0;
  shbp_op_t    reqOp = SHBP_OP_RD_REG;
  logic [7:1]  reqAddr = 7'h00;
  logic [15:0] reqData = 16'h0000;
  logic [15:0] rxData = 16'h0000;
  logic [1:0]  cfgValue = 2'h2;
  logic        reqReady, rspValid, rxReady, txValid;
  logic [15:0] rspData, txData, freeCount, got, v;
  logic [1:0]  cfgStrap;
  logic [15:0] edgeCount = 16'h0000;
  logic [15:0] startCount = 16'h0000;
  logic [15:0] rxQ[$];
  logic [15:0] txQ[$];
  int          seed = 37;
  int          miscompares = 0;
  int          totalChecks = 0;
  int          i, n;
  always #5 clock = ~clock;
  // Counter model: steps on every edge once reset is released
  always @(posedge clock) begin
    if (rstn === 1'b1) edgeCount <= edgeCount + 16'h0001;
  end
  shbp_if bus();
  shbp_host #(.RST_CYC(10)) u_shbp_host (.clock(clock), .rstn(rstn), .bus(bus), .reqValid(reqValid),
    .reqOp(reqOp), .reqAddr(reqAddr), .reqData(reqData), .cfgValue(cfgValue), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData));
  shbp_device u_shbp_device (.clock(clock), .rstn(rstn), .bus(bus), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .txData(txData), .txValid(txValid), .txReady(txReady), .cfgStrap(cfgStrap),
    .freeCount(freeCount));
  shbp_sva u_shbp_sva (.clock(clock), .rstn(rstn), .chipSelectN(bus.chipSelectN),
    .readStrobeN(bus.readStrobeN), .writeStrobeN(bus.writeStrobeN), .fifoSel(bus.fifoSel),
    .addr(bus.addr), .dataDev(bus.dataDev), .dataDevOe(bus.dataDevOe), .resetPinN(bus.resetPinN));
  task check(input logic [15:0] act, input logic [15:0] exp);
    totalChecks++;
    if (act !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, act, exp);
    end
  endtask
  task giveVerdict;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task waitFail;
    miscompares++;
    $display("ERROR %0t: wait timed out", $time);
    giveVerdict();
  endtask
  // Write ops have no response; one idle edge keeps reqValid from a double assignment
  task access(input shbp_op_t op, input logic [7:1] a, input logic [15:0] d, output logic [15:0] r);
    reqOp <= op;
    reqAddr <= a;
    reqData <= d;
    reqValid <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (reqReady !== 1'b1 && n < 300);
    startCount = edgeCount;
    reqValid <= 1'b0;
    if (reqReady !== 1'b1) waitFail();
    r = 16'h0000;
    n = 0;
    if (op == SHBP_OP_RD_REG || op == SHBP_OP_RD_FIFO) begin
      do begin @(posedge clock); n++; end while (rspValid !== 1'b1 && n < 20);
      if (rspValid !== 1'b1) waitFail();
      r = rspData;
    end else @(posedge clock);
  endtask
  initial begin
    cfgValue <= 2'($random(seed));
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (bus.resetPinN !== 1'b1 && n < 100);
    if (bus.resetPinN !== 1'b1) waitFail();
    repeat (2) @(posedge clock);
    check(16'(cfgStrap), 16'(cfgValue));
    v = 16'($random(seed));
    access(SHBP_OP_WR_REG, 7'h03, v, got);
    access(SHBP_OP_RD_REG, 7'h03, 16'h0000, got);
    check(got, v);
    access(SHBP_OP_RD_REG, 7'h01, 16'h0000, got);
    check(got, {14'h0000, cfgValue});
    access(SHBP_OP_RD_REG, 7'h05, 16'h0000, got);
    check(got, 16'h0000);
    access(SHBP_OP_RD_REG, 7'h00, 16'h0000, got);
    check(got, startCount);
    check(freeCount, edgeCount - 16'h0001);
    // Fill past depth: the ninth and tenth offers must be refused
    for (i = 0; i < 10; i++) begin
      v = 16'($random(seed));
      rxData <= v;
      rxValid <= 1'b1;
      @(posedge clock);
      if (rxReady === 1'b1) rxQ.push_back(v);
    end
    rxValid <= 1'b0;
    check(16'(rxQ.size()), 16'h0008);
    check(16'(rxReady), 16'h0000);
    access(SHBP_OP_RD_REG, 7'h02, 16'h0000, got);
    check(got, {8'h00, 4'(rxQ.size()), 4'h0});
    // Random A[7:1] including reads past empty
    for (i = 0; i < 10; i++) begin
      access(SHBP_OP_RD_FIFO, 7'($random(seed)), 16'h0000, got);
      check(got, (rxQ.size() > 0) ? rxQ.pop_front() : 16'h0000);
    end
    // Far side stalls while nine words arrive; the last is lost
    for (i = 0; i < 9; i++) begin
      v = 16'($random(seed));
      access(SHBP_OP_WR_FIFO, 7'($random(seed)), v, got);
      if (i < 8) txQ.push_back(v);
    end
    // Ninth word was refused, so the loss flag must be up
    access(SHBP_OP_RD_REG, 7'h02, 16'h0000, got);
    check(got, {7'h00, 1'b1, 4'h0, 4'(txQ.size())});
    txReady <= 1'b1;
    n = 0;
    while (n < 40) begin
      @(posedge clock);
      n++;
      if (txValid === 1'b1) check(txData, (txQ.size() > 0) ? txQ.pop_front() : 16'hFFFF);
    end
    check(16'(txQ.size()), 16'h0000);
    giveVerdict();
  end
endmodule
`default_nettype wire

// ---- test/shbp_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module shbp_sva (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        chipSelectN,
  input wire logic        readStrobeN,
  input wire logic        writeStrobeN,
  input wire logic        fifoSel,
  input wire logic [7:1]  addr,
  input wire logic [15:0] dataDev,
  input wire logic        dataDevOe,
  input wire logic        resetPinN
);
  logic rdAct;
  logic wrAct;
  logic acc;
  assign rdAct = !chipSelectN && !readStrobeN;
  assign wrAct = !chipSelectN && !writeStrobeN;
  assign acc   = rdAct || wrAct;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_oe_in_read: assert property (dataDevOe |-> rdAct)
    else $error("data bus driven outside a read");
  a_oe_drop: assert property ($fell(rdAct) |-> !dataDevOe)
    else $error("data bus held after read end");
  a_oe_start: assert property ($rose(rdAct) ##1 rdAct |-> dataDevOe)
    else $error("read data not driven");
  a_no_oe_write: assert property (wrAct |-> !dataDevOe)
    else $error("data bus driven in a write");
  a_one_strobe: assert property (!(!readStrobeN && !writeStrobeN))
    else $error("both strobes low");
  a_low_time: assert property ($rose(acc) |-> acc[*4])
    else $error("access shorter than four cycles");
  a_gap_time: assert property ($fell(acc) |-> (!acc)[*2])
    else $error("gap shorter than two cycles");
  a_cycle_time: assert property ($rose(acc) |=> (!$rose(acc))[*4])
    else $error("accesses closer than five cycles");
  // Counter read data must hold steady under an open read
  a_snap_hold: assert property (dataDevOe && $past(dataDevOe) && !fifoSel && addr == 7'h00 && $stable(addr)
    |-> $stable(dataDev)) else $error("counter moved within a read");
  a_sel_hold: assert property (acc && $past(acc) |-> $stable(fifoSel) && $stable(addr))
    else $error("select or address moved in access");
  a_reset_idle: assert property (!resetPinN |-> chipSelectN)
    else $error("access during device reset");
endmodule
`default_nettype wire
